// *** rtl/pdcr_config_regs.sv ***
// pll divider configuration registers with serial access and setting select
// assumes serial pins and select pins are asynchronous to mclk, and vco_tick
// is a one-cycle pulse already in the mclk domain
`timescale 1ns/100ps

module pdcr_config_regs #(
  parameter int NUM_SETTINGS = pdcr_pkg::NUM_SETTINGS
) (
  // clock and reset
  input wire logic mclk,
  input wire logic rst,
  // serial configuration port
  input wire logic ser_clk,
  input wire logic ser_frame_n,
  input wire logic ser_din,
  output logic ser_dout,
  output logic ser_dout_oe,
  // setting select pins
  input wire logic setting_select_bit0,
  input wire logic setting_select_bit1,
  input wire logic setting_select_bit2,
  // vco tick in, divided tick out
  input wire logic vco_tick,
  output logic out_tick,
  // configuration outputs
  output pdcr_pkg::pdcr_cfg_type cfg,
  output pdcr_pkg::pdcr_terms_type terms,
  output logic [8:0] ref_divider,
  output logic [7:0] active_setting,
  output logic [1:0] second_set_vco_band
);

  // ==========================================================================
  // elaboration check
  if (NUM_SETTINGS != 8) begin : g_bad_count
    $error("three select pins address exactly eight settings");
  end

  typedef enum logic [1:0] {ST_IDLE, ST_CMD, ST_DATA, ST_HOLD} pdcr_state_type;

  // ==========================================================================
  // pin synchronisers
  logic [5:0] pin_meta_reg;
  logic [5:0] pin_sync_reg;
  logic clk_prev_reg;
  wire [5:0] pin_raw = {setting_select_bit2, setting_select_bit1,
    setting_select_bit0, ser_din, ser_frame_n, ser_clk};

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      pin_meta_reg <= 6'h02;
      pin_sync_reg <= 6'h02;
      clk_prev_reg <= 1'b0;
    end else begin
      pin_meta_reg <= pin_raw;
      pin_sync_reg <= pin_meta_reg;
      clk_prev_reg <= pin_sync_reg[0];
    end
  end

  wire frame_active = !pin_sync_reg[1];
  wire bit_strobe = frame_active && pin_sync_reg[0] && !clk_prev_reg;
  wire [2:0] sel_pins = pin_sync_reg[5:3];

  // ==========================================================================
  // serial frame: command byte (bit 7 read, 6:0 offset), then one data byte
  pdcr_state_type state_reg, state_next;
  logic [7:0] cmd_reg;
  logic [7:0] rx_byte;
  logic rx_done;
  logic [7:0] rd_byte;
  logic tx_bit;

  wire cmd_read = cmd_reg[pdcr_pkg::CMD_READ_POS];
  wire [6:0] offset = cmd_reg[6:0];
  wire load_rd = (state_reg == ST_CMD) && rx_done &&
    rx_byte[pdcr_pkg::CMD_READ_POS];
  wire wr_en = (state_reg == ST_DATA) && rx_done && !cmd_read &&
    (offset < pdcr_pkg::OFF_WRITE_LIMIT);

  // next-state decode; leaving the frame always returns to idle
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ST_IDLE: state_next = frame_active ? ST_CMD : ST_IDLE;
      ST_CMD: state_next = rx_done ? ST_DATA : ST_CMD;
      ST_DATA: state_next = rx_done ? ST_HOLD : ST_DATA;
      ST_HOLD: state_next = ST_HOLD;
      default: state_next = ST_IDLE;
    endcase
    if (!frame_active) begin
      state_next = ST_IDLE;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      state_reg <= ST_IDLE;
      cmd_reg <= 8'h00;
    end else begin
      state_reg <= state_next;
      if (state_reg == ST_CMD && rx_done) begin
        cmd_reg <= rx_byte;
      end
    end
  end

  pdcr_byte_shifter u_shifter (
    .mclk(mclk),
    .rst(rst),
    .clear(!frame_active),
    .bit_strobe(bit_strobe),
    .bit_in(pin_sync_reg[2]),
    .load(load_rd),
    .load_byte(rd_byte),
    .byte_out(rx_byte),
    .bit_out(tx_bit),
    .byte_done(rx_done)
  );

  // drive the data pin only while a read byte is going out
  assign ser_dout_oe = (state_reg == ST_DATA) && cmd_read;
  assign ser_dout = ser_dout_oe && tx_bit;

  // ==========================================================================
  // register file
  logic [7:0] fb_high_reg, fb_low_reg, rem_low_reg, q_low_reg;
  logic [7:0] ref_low_reg;
  logic ref_high_reg;
  logic [6:0] post_div_reg;
  logic [7:0] setting_reg [NUM_SETTINGS];

  wire [6:0] set_rel = offset - pdcr_pkg::OFF_SETTING_BASE;
  wire set_hit = (offset >= pdcr_pkg::OFF_SETTING_BASE) &&
    (set_rel < 7'(NUM_SETTINGS));

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      fb_high_reg <= pdcr_pkg::RST_FB_HIGH;
      fb_low_reg <= pdcr_pkg::RST_FB_LOW;
      rem_low_reg <= pdcr_pkg::RST_REM_LOW;
      q_low_reg <= pdcr_pkg::RST_Q_LOW;
      ref_high_reg <= pdcr_pkg::RST_REF_HIGH;
      ref_low_reg <= pdcr_pkg::RST_REF_LOW;
      post_div_reg <= pdcr_pkg::RST_POST_DIV;
    end else if (wr_en) begin
      case (offset)
        pdcr_pkg::OFF_FB_HIGH: fb_high_reg <= rx_byte;
        pdcr_pkg::OFF_FB_LOW: fb_low_reg <= rx_byte;
        pdcr_pkg::OFF_REM_LOW: rem_low_reg <= rx_byte;
        pdcr_pkg::OFF_Q_LOW: q_low_reg <= rx_byte;
        pdcr_pkg::OFF_REF_HIGH: ref_high_reg <= rx_byte[0];
        pdcr_pkg::OFF_REF_LOW: ref_low_reg <= rx_byte;
        pdcr_pkg::OFF_POST_DIV: post_div_reg <= rx_byte[6:0];
        default: ;
      endcase
    end
  end

  // one byte per stored control setting
  for (genvar i = 0; i < NUM_SETTINGS; i++) begin : g_setting
    always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
        setting_reg[i] <= pdcr_pkg::RST_SETTING;
      end else if (wr_en && set_hit && set_rel == 7'(i)) begin
        setting_reg[i] <= rx_byte;
      end
    end
  end

  // read-back mux; unmapped offsets read as zero
  always_comb begin
    rd_byte = 8'h00;
    case (rx_byte[6:0])
      pdcr_pkg::OFF_FB_HIGH: rd_byte = fb_high_reg;
      pdcr_pkg::OFF_FB_LOW: rd_byte = fb_low_reg;
      pdcr_pkg::OFF_REM_LOW: rd_byte = rem_low_reg;
      pdcr_pkg::OFF_Q_LOW: rd_byte = q_low_reg;
      pdcr_pkg::OFF_REF_HIGH: rd_byte = {7'h00, ref_high_reg};
      pdcr_pkg::OFF_REF_LOW: rd_byte = ref_low_reg;
      pdcr_pkg::OFF_POST_DIV: rd_byte = {1'b0, post_div_reg};
      default: rd_byte = 8'h00;
    endcase
    if (rx_byte[6:0] >= pdcr_pkg::OFF_SETTING_BASE &&
        rx_byte[6:0] < pdcr_pkg::OFF_REF_HIGH) begin
      rd_byte = setting_reg[rx_byte[2:0]];
    end
  end

  // ==========================================================================
  // field reassembly: high part from lower offset, low part from next
  wire [11:0] fb_count = {fb_high_reg, fb_low_reg[7:pdcr_pkg::FB_LOW_POS]};
  wire [8:0] ref_div = {ref_high_reg, ref_low_reg};
  pdcr_pkg::pdcr_cfg_type cfg_next;

  always_comb begin
    cfg_next.feedback = fb_count;
    cfg_next.remainder = {fb_low_reg[3:0],
      rem_low_reg[7:pdcr_pkg::REM_LOW_POS]};
    cfg_next.quotient = {rem_low_reg[2:0],
      q_low_reg[7:pdcr_pkg::Q_LOW_POS]};
    cfg_next.shift = q_low_reg[4:pdcr_pkg::SHIFT_POS];
    cfg_next.band = q_low_reg[1:0];
  end

  // ==========================================================================
  // divider terms; a wide combinational divide, registered once per cycle
  pdcr_pkg::pdcr_terms_type terms_next;
  logic [3:0] log_k;
  logic [15:0] ref16;
  logic [15:0] prod;

  always_comb begin
    log_k = 4'h0;
    ref16 = {7'h00, ref_div};
    for (int k = 1; k <= pdcr_pkg::LOG_MAX; k++) begin
      if (({12'h000, ref_div} << k) <= {9'h000, fb_count}) begin
        log_k = 4'(k);
      end
    end
    // below unity ratio the shift stops at the base value
    if (fb_count < {3'h0, ref_div} || log_k >= 4'(pdcr_pkg::SHIFT_BASE)) begin
      terms_next.shift = (fb_count < {3'h0, ref_div}) ?
        pdcr_pkg::SHIFT_BASE : 3'h0;
    end else begin
      terms_next.shift = pdcr_pkg::SHIFT_BASE - log_k[2:0];
    end
    terms_next.scaled = {4'h0, fb_count} << terms_next.shift;
    terms_next.quotient = (ref_div == 9'h000) ? 16'h0000 :
      terms_next.scaled / ref16;
    prod = 16'(ref16 * terms_next.quotient);
    terms_next.remainder = 9'(terms_next.scaled - prod);
  end

  // ==========================================================================
  // output registers: applied setting, fields, terms
  logic [7:0] active_reg;
  pdcr_pkg::pdcr_cfg_type cfg_reg;
  pdcr_pkg::pdcr_terms_type terms_reg;

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      active_reg <= pdcr_pkg::RST_SETTING;
      cfg_reg <= '0;
      terms_reg <= '0;
    end else begin
      active_reg <= setting_reg[sel_pins];
      cfg_reg <= cfg_next;
      terms_reg <= terms_next;
    end
  end

  assign active_setting = active_reg;
  assign cfg = cfg_reg;
  assign terms = terms_reg;
  assign second_set_vco_band = cfg_reg.band;
  assign ref_divider = ref_div;

  // ==========================================================================
  // post divider on vco ticks; zero is served as one
  logic [6:0] div_cnt_reg;
  logic out_tick_reg;
  wire [6:0] post_div_eff = (post_div_reg == 7'h00) ? 7'h01 : post_div_reg;

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      div_cnt_reg <= 7'h00;
      out_tick_reg <= 1'b0;
    end else begin
      out_tick_reg <= vco_tick && (div_cnt_reg >= post_div_eff - 7'h01);
      if (vco_tick) begin
        div_cnt_reg <= (div_cnt_reg >= post_div_eff - 7'h01) ? 7'h00 :
          div_cnt_reg + 7'h01;
      end
    end
  end

  assign out_tick = out_tick_reg;

  // ==========================================================================
  // checks
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  // helper: vco ticks since the last output tick, and a post divider edit flag
  logic [7:0] since_reg;
  logic pd_edit_reg;
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      since_reg <= 8'h00;
      pd_edit_reg <= 1'b1;
    end else begin
      if (out_tick_reg) begin
        since_reg <= {7'h00, vco_tick};
      end else if (vco_tick) begin
        since_reg <= since_reg + 8'h01;
      end
      pd_edit_reg <= (wr_en && offset == pdcr_pkg::OFF_POST_DIV) ||
        (pd_edit_reg && !out_tick_reg);
    end
  end

  sequence s_write_at(logic [6:0] off);
    wr_en && offset == off;
  endsequence

  a_write_limit_drop: assert property (
    ((state_reg == ST_DATA) && rx_done && !cmd_read &&
      offset >= pdcr_pkg::OFF_WRITE_LIMIT) |=>
      $stable(fb_high_reg) && $stable(q_low_reg) && $stable(post_div_reg))
    else $error("write above limit changed a register");

  a_setting_store: assert property (
    (wr_en && set_hit) |=> setting_reg[$past(set_rel[2:0])] == $past(rx_byte))
    else $error("setting byte not stored");

  a_setting_apply: assert property (
    ($stable(sel_pins) && !wr_en)[*4] |->
      active_reg == setting_reg[sel_pins])
    else $error("selected setting not applied");

  a_feedback_split: assert property (
    s_write_at(pdcr_pkg::OFF_FB_HIGH) ##1 !wr_en |=>
      cfg_reg.feedback[11:4] == $past(rx_byte, 2))
    else $error("feedback high bits misplaced");

  a_vco_band_field: assert property (
    s_write_at(pdcr_pkg::OFF_Q_LOW) ##1 !wr_en |=>
      second_set_vco_band == $past(rx_byte[1:0], 2))
    else $error("vco band field misplaced");

  a_shift_term_calc: assert property (
    (ref_div != 9'h000 && fb_count >= {3'h0, ref_div} &&
      fb_count < {2'h0, ref_div, 1'b0}) |=> terms_reg.shift == 3'h4)
    else $error("shift term wrong for ratio below two");

  a_quot_rem_pair: assert property (
    (ref_div != 9'h000 && $stable(ref_div)) |->
      (16'(terms_reg.quotient * ref16) + {7'h00, terms_reg.remainder} ==
        terms_reg.scaled) && ({7'h00, terms_reg.remainder} < ref16))
    else $error("quotient and remainder do not rebuild the scaled count");

  a_post_div_period: assert property (
    (out_tick_reg && !pd_edit_reg && $past(!out_tick_reg)) |->
      since_reg == {1'b0, post_div_eff})
    else $error("output tick period differs from post divider");

endmodule

// *** rtl/pdcr_pkg.sv ***
// package for the pll divider configuration register block
// assumes one byte-wide register space reached over a three-wire serial port
package pdcr_pkg;

  // ==========================================================================
  // register offsets (seven-bit space, from the command byte)
  localparam logic [6:0] OFF_FB_HIGH = 7'h3c;
  localparam logic [6:0] OFF_FB_LOW = 7'h3d;
  localparam logic [6:0] OFF_REM_LOW = 7'h3e;
  localparam logic [6:0] OFF_Q_LOW = 7'h3f;
  localparam logic [6:0] OFF_SETTING_BASE = 7'h10;
  localparam logic [6:0] OFF_REF_HIGH = 7'h18;
  localparam logic [6:0] OFF_REF_LOW = 7'h19;
  localparam logic [6:0] OFF_POST_DIV = 7'h1a;
  localparam logic [6:0] OFF_WRITE_LIMIT = 7'h40;

  // ==========================================================================
  // reset values
  localparam logic [7:0] RST_FB_HIGH = 8'hff;
  localparam logic [7:0] RST_FB_LOW = 8'h80;
  localparam logic [7:0] RST_REM_LOW = 8'h02;
  localparam logic [7:0] RST_Q_LOW = 8'h04;
  localparam logic [7:0] RST_SETTING = 8'h00;
  localparam logic [0:0] RST_REF_HIGH = 1'h1 - 1'h1;
  localparam logic [7:0] RST_REF_LOW = 8'h01;
  localparam logic [6:0] RST_POST_DIV = 7'h01;

  // ==========================================================================
  // field positions and arithmetic constants
  localparam int CMD_READ_POS = 7;
  localparam int FB_LOW_POS = 4;
  localparam int REM_LOW_POS = 3;
  localparam int Q_LOW_POS = 5;
  localparam int SHIFT_POS = 2;
  localparam logic [2:0] SHIFT_BASE = 3'h4;
  localparam int LOG_MAX = 11;
  localparam int NUM_SETTINGS = 8;

  // reassembled divider fields
  typedef struct packed {
    logic [11:0] feedback;
    logic [8:0] remainder;
    logic [5:0] quotient;
    logic [2:0] shift;
    logic [1:0] band;
  } pdcr_cfg_type;

  // divider terms worked out from feedback count and reference divider
  typedef struct packed {
    logic [2:0] shift;
    logic [15:0] scaled;
    logic [15:0] quotient;
    logic [8:0] remainder;
  } pdcr_terms_type;

endpackage

// *** rtl/pdcr_byte_shifter.sv ***
// byte shift register for the serial configuration port
// assumes bit strobes come from a synchronised, edge-detected serial clock
`timescale 1ns/100ps

module pdcr_byte_shifter (
  // clock and reset
  input wire logic mclk,
  input wire logic rst,
  // control
  input wire logic clear,
  input wire logic bit_strobe,
  input wire logic bit_in,
  input wire logic load,
  input wire logic [7:0] load_byte,
  // results
  output logic [7:0] byte_out,
  output logic bit_out,
  output logic byte_done
);

  logic [7:0] shift_reg;
  logic [2:0] count_reg;
  logic done_reg;

  // msb leaves first, new bits enter at the lsb
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      shift_reg <= 8'h00;
      count_reg <= 3'h0;
      done_reg <= 1'b0;
    end else if (clear) begin
      count_reg <= 3'h0;
      done_reg <= 1'b0;
    end else if (load) begin
      shift_reg <= load_byte;
      done_reg <= 1'b0;
    end else begin
      if (bit_strobe) begin
        shift_reg <= {shift_reg[6:0], bit_in};
        count_reg <= count_reg + 3'h1;
      end
      done_reg <= bit_strobe && (count_reg == 3'h7);
    end
  end

  assign byte_out = shift_reg;
  assign bit_out = shift_reg[7];
  assign byte_done = done_reg;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  a_msb_first_shift: assert property (
    (bit_strobe && !load && !clear) |=>
      (shift_reg[0] == $past(bit_in)) &&
      (shift_reg[7:1] == $past(shift_reg[6:0])))
    else $error("shift order is not msb first");

endmodule

// *** testbench/pdcr_host_model.sv ***
// host model for the serial configuration port
// assumes the bench calls xfer; pins change only after mclk edges
`timescale 1ns/100ps

module pdcr_host_model (
  // clock
  input wire logic mclk,
  // serial pins
  output logic ser_clk,
  output logic ser_frame_n,
  output logic ser_din,
  input wire logic ser_dout,
  input wire logic ser_dout_oe
);
  // ==========================================================
  // idle pins: serial clock parked low, frame high
  initial begin
    ser_clk = 1'b0;
    ser_frame_n = 1'b1;
    ser_din = 1'b0;
  end

  // ==========================================================
  // one frame: command byte then data byte, four-cycle setup
  // offsets from 40h up only when a test asks for it
  task automatic xfer(input logic [7:0] cmd, input logic [7:0] wd,
                      output logic [7:0] rd);
    logic [15:0] sh;
    sh = {cmd, wd};
    rd = 8'h00;
    @(posedge mclk) ser_frame_n <= 1'b0;
    repeat (4) @(posedge mclk);
    for (int i = 15; i >= 0; i--) begin
      ser_din <= sh[i];
      repeat (3) @(posedge mclk);
      // sample off the edge where the device updates its output
      @(negedge mclk) if (i < 8) rd[i] = ser_dout_oe ? ser_dout : 1'bx;
      @(posedge mclk) ser_clk <= 1'b1;
      repeat (8) @(posedge mclk);
      ser_clk <= 1'b0;
      repeat (4) @(posedge mclk);
    end
    ser_frame_n <= 1'b1;
    // released line shows the inverse, so a stale bit cannot pass
    ser_din <= ~sh[0];
    repeat (4) @(posedge mclk);
  endtask
endmodule

// *** testbench/pll_divider_config_regs_bench.sv ***
// self-checking bench for the pll divider configuration registers
// assumes the host model drives the serial pins, the bench the rest
`timescale 1ns/100ps
`define CHK(nm, ex, got) begin comparisons++; if ((got) !== (ex)) begin \
  err_count++; $display("[FAIL] %s expected %h seen %h", nm, ex, got); end end

module pll_divider_config_regs_bench;
  logic mclk, rst, sel0, sel1, sel2, vco_tick, out_tick;
  logic ser_clk, ser_frame_n, ser_din, ser_dout, ser_dout_oe;
  pdcr_pkg::pdcr_cfg_type cfg;
  pdcr_pkg::pdcr_terms_type terms;
  logic [8:0] ref_divider;
  logic [7:0] active_setting, rd;
  logic [1:0] band;
  int err_count = 0;
  int comparisons = 0;
  int seed = 32'h1656;
  int regm [0:127];
  // last pair keeps the ratio between one and two for the shift-term check
  int nt [5] = '{4, 11, 4095, 1, 700};
  int mt [5] = '{1, 2, 1, 511, 500};
  int dt [3] = '{1, 5, 127};
  int n, m, p, outs, outs0;

  pdcr_host_model i_host (.mclk(mclk), .ser_clk(ser_clk),
    .ser_frame_n(ser_frame_n), .ser_din(ser_din), .ser_dout(ser_dout),
    .ser_dout_oe(ser_dout_oe));

  pdcr_config_regs i_dut (.mclk(mclk), .rst(rst), .ser_clk(ser_clk),
    .ser_frame_n(ser_frame_n), .ser_din(ser_din), .ser_dout(ser_dout),
    .ser_dout_oe(ser_dout_oe), .setting_select_bit0(sel0),
    .setting_select_bit1(sel1), .setting_select_bit2(sel2),
    .vco_tick(vco_tick), .out_tick(out_tick), .cfg(cfg), .terms(terms),
    .ref_divider(ref_divider), .active_setting(active_setting),
    .second_set_vco_band(band));

  // ==========================================================
  // clock and divided tick counter
  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end

  initial outs = 0;
  always @(posedge mclk) if (out_tick === 1'b1) outs <= outs + 1;

  // ==========================================================
  // model arithmetic: largest k with m shifted by k not above n
  function automatic int shift_of(input int nn, input int mm);
    int k;
    k = 0;
    if (nn < mm) return 4;
    while ((mm << (k + 1)) <= nn) k++;
    return (k >= 4) ? 0 : 4 - k;
  endfunction

  task automatic settle(input int c);
    repeat (c) @(posedge mclk);
    @(negedge mclk);
  endtask

  // writes at 40h and above never reach the image
  task automatic wr(input int off, input int d);
    i_host.xfer(8'(off), 8'(d), rd);
    if (off < 'h40) regm[off] = d & 'hff;
  endtask

  task automatic rd_chk(input int off);
    i_host.xfer(8'('h80 | off), 8'h00, rd);
    `CHK("read byte", 8'(regm[off]), rd)
  endtask

  // joined fields and divider terms against the register image
  task automatic chk_cfg();
    settle(3);
    n = (regm['h3c] << 4) | (regm['h3d] >> 4);
    m = ((regm['h18] & 1) << 8) | regm['h19];
    p = shift_of(n, m);
    `CHK("feedback", 12'(n), cfg.feedback)
    `CHK("rem field", 9'(((regm['h3d] & 15) << 5) | (regm['h3e] >> 3)),
         cfg.remainder)
    `CHK("q field", 6'(((regm['h3e] & 7) << 3) | (regm['h3f] >> 5)),
         cfg.quotient)
    `CHK("p field", 3'((regm['h3f] >> 2) & 7), cfg.shift)
    `CHK("band", 2'(regm['h3f] & 3), band)
    `CHK("band field", 2'(regm['h3f] & 3), cfg.band)
    `CHK("ref divider", 9'(m), ref_divider)
    `CHK("shift term", 3'(p), terms.shift)
    `CHK("scaled", 16'(n << p), terms.scaled)
    `CHK("quotient", 16'((n << p) / m), terms.quotient)
    `CHK("remainder", 9'((n << p) % m), terms.remainder)
  endtask

  task automatic done(input string nm);
    $display("test %s finished, mismatches so far %0d", nm, err_count);
  endtask

  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  // ==========================================================
  // watchdog: the whole run needs about 20500 cycles
  initial begin
    repeat (60000) @(posedge mclk);
    err_count++;
    $display("[FAIL] watchdog expected finish seen hang");
    print_verdict();
  end

  // ==========================================================
  // main sequence
  initial begin
    rst = 1'b1;
    {sel2, sel1, sel0} = 3'h0;
    vco_tick = 1'b0;
    foreach (regm[i]) regm[i] = 0;
    regm['h3c] = 'hff;
    regm['h3d] = 'h80;
    regm['h3e] = 'h02;
    regm['h3f] = 'h04;
    regm['h19] = 1;
    repeat (6) @(posedge mclk);
    rst <= 1'b0;
    settle(4);
    `CHK("setting at reset", 8'h00, active_setting)
    chk_cfg();
    for (int a = 'h3c; a <= 'h3f; a++) rd_chk(a);
    done("reset");
    for (int b = 0; b < 4; b++) begin
      wr('h3f, ($random(seed) & 'hfc) | b);
      chk_cfg();
    end
    done("band");
    // documented examples and extremes first, then random picks
    for (int i = 0; i < 10; i++) begin
      n = (i < 5) ? nt[i] : 1 + ({$random(seed)} % 4095);
      m = (i < 5) ? mt[i] : 1 + ({$random(seed)} % 511);
      wr('h3c, n >> 4);
      wr('h3d, ((n & 15) << 4) | ($random(seed) & 15));
      wr('h18, m >> 8);
      wr('h19, m & 'hff);
      chk_cfg();
    end
    done("divider");
    // a stray write above the limit must leave no trace
    wr('h41, 'h5a);
    rd_chk('h41);
    rd_chk('h3c);
    done("limit");
    for (int s = 0; s < 8; s++) wr('h10 + s, $random(seed));
    for (int s = 7; s >= 0; s--) begin
      @(posedge mclk) {sel2, sel1, sel0} <= 3'(s);
      settle(5);
      `CHK("active", 8'(regm['h10 + s]), active_setting)
      rd_chk('h10 + s);
    end
    rd_chk('h18);
    rd_chk('h19);
    done("select");
    for (int j = 0; j < 3; j++) begin
      wr('h1a, dt[j]);
      outs0 = outs;
      for (int t = 0; t < 2 * dt[j]; t++) begin
        @(posedge mclk) vco_tick <= 1'b1;
        @(posedge mclk) vco_tick <= 1'b0;
      end
      settle(3);
      `CHK("out ticks", 8'h02, 8'(outs - outs0))
      rd_chk('h1a);
    end
    done("post divider");
    print_verdict();
  end
endmodule
